// ---- logic/fbc_ctrl.sv ----
// Host-side bus controller for an asynchronous parallel flash
//
// Behaviour
// RQ1: After reset release reads return array data with no command written first.
// RQ2: Reads of array, identifier and status work at any programming supply level.
// RQ3: Contents-altering operations need a setup write followed by a confirm write.
// RQ4: Flash latches address and data per write; host need not hold afterwards.
// RQ5: Last read-mode command selects array, identifier or status output.
// RQ6: Host drives chip select and output gate active to read data.
// RQ7: Output gate high keeps flash data lines floating.
// RQ8: Chip select high puts flash in standby with data lines floating.
// RQ9: Deselecting during an operation lets that operation run to completion.
// RQ10: Reset low in read modes deselects flash and floats its outputs.
// RQ11: Host holds reset low at least 100 ns per assertion.
// RQ12: Host waits the wake time after reset before trusting read data.
// RQ13: Leaving reset restores read array mode and status value 80H.
// RQ14: Reset during an operation aborts it; ready/busy low until reset done.
// RQ15: Host waits the reset-to-write interval before any command write.
// RQ16: Flash ignores writes under supply lockout or while reset is low.
// RQ17: Block locking gates erase and write of locked blocks.
// RQ18: Bottom boot layout: two boot, six parameter, fifteen main blocks.
// RQ19: Erase may be suspended for other access; write suspended for reads.
// RQ20: Internal state machine repeats pulses, verifies and margins by itself.
// RQ21: Flash latches address and data on write strobe rising edge.
// RQ22: Width select low is byte-wide on low lines; high is word-wide.
// RQ23: Ready/busy is pulled low while an operation runs, released otherwise.
// RQ24: During reads host keeps write strobe high and reset high.
`timescale 1ns/1ps
module fbc_ctrl
   import fbc_pkg::*;
#(
   parameter int WAKE_NS = WAKE_NS_DEF,
   parameter int W2_NS   = W2_NS_DEF,
   parameter int RD_CYC  = RD_CYC_DEF,
   parameter int WE_CYC  = WE_CYC_DEF
) (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        REQ_VALID,
   input  wire fbc_req_t    REQ,
   input  wire logic        WORD_MODE,
   output logic             REQ_READY,
   output logic             RSP_VALID,
   output logic [15:0]      RSP_DATA,
   output logic             FLASH_BUSY,
   output fbc_pins_t        PINS,
   input  wire logic [15:0] DATA_IN,
   input  wire logic        READY_BUSY_OUT
);

   // ******************************************
   // Timing counts
   // ******************************************
   localparam int WAKE_CYC_I = (WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int W2_CYC_I   = (W2_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [9:0] WAKE_CYC = 10'(WAKE_CYC_I < 1 ? 1 : WAKE_CYC_I);
   localparam logic [9:0] W2_CYC   = 10'(W2_CYC_I < 1 ? 1 : W2_CYC_I);
   localparam logic [7:0] RSTL_END = 8'(RST_LOW_CYC - 1);
   localparam logic [7:0] RD_END   = 8'(RD_CYC + SYNC_CYC - 1);
   localparam logic [7:0] WE_END   = 8'(WE_CYC - 1);

   // ******************************************
   // State
   // ******************************************
   typedef struct packed {
      fbc_state_t  st;
      logic [7:0]  cnt;
      logic [9:0]  since_rp;
      fbc_pins_t   pins;
      logic [15:0] data2;
      logic        two;
      logic        rdy;
      logic        rsp_v;
      logic [15:0] rsp_d;
      logic        busy;
   } fbc_ctrl_t;

   // Power-up holds reset low so the flash starts in a known mode
   localparam fbc_ctrl_t RST_VAL = '{
      st: S_RST_LOW, cnt: 8'h00, since_rp: 10'h000,
      pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rp_n: 1'b0, addr: 19'h00000,
               addr_lsb: 1'b0, word_wide: 1'b1, dout: 16'h0000, doe: 1'b0},
      data2: 16'h0000, two: 1'b0, rdy: 1'b0, rsp_v: 1'b0, rsp_d: 16'h0000,
      busy: 1'b0};

   fbc_ctrl_t   state_reg;
   fbc_ctrl_t   state_next;
   logic [15:0] data_sync;
   logic        busy_sync;

   fbc_sync #(.W(16)) u_data_sync (
      .CLK (CLK),
      .RST (RST),
      .d   (DATA_IN),
      .q   (data_sync)
   );

   // Inverted before sync so the flops' reset value reads as not busy
   fbc_sync #(.W(1)) u_rb_sync (
      .CLK (CLK),
      .RST (RST),
      .d   (~READY_BUSY_OUT),
      .q   (busy_sync)
   );

   // ******************************************
   // Next state
   // ******************************************
   always_comb begin
      state_next       = state_reg;
      state_next.rsp_v = 1'b0;
      state_next.busy  = busy_sync; // RQ23 RQ14
      if (state_reg.pins.rp_n && state_reg.since_rp != SINCE_MAX) begin
         state_next.since_rp = state_reg.since_rp + 10'h001;
      end
      case (state_reg.st)
         S_RST_LOW: begin
            state_next.cnt = state_reg.cnt + 8'h01;
            if (state_reg.cnt >= RSTL_END) begin // RQ11
               state_next.pins.rp_n = 1'b1;
               state_next.since_rp  = 10'h000;
               state_next.cnt       = 8'h00;
               state_next.st        = S_IDLE;
            end
         end
         S_IDLE: begin
            state_next.rdy = 1'b1;
            if (REQ_VALID && state_reg.rdy) begin
               state_next.rdy                = 1'b0;
               state_next.cnt                = 8'h00;
               state_next.pins.addr          = REQ.addr;
               state_next.pins.addr_lsb      = REQ.addr_lsb;
               state_next.pins.word_wide     = WORD_MODE; // RQ22
               state_next.pins.dout          = REQ.data;
               state_next.data2              = REQ.data2;
               state_next.two                = (REQ.op == OP_WRITE2); // RQ3
               case (REQ.op)
                  OP_RESET: begin
                     state_next.pins.rp_n = 1'b0; // RQ14
                     state_next.st        = S_RST_LOW;
                  end
                  OP_READ: begin
                     state_next.st = S_RD_WAIT;
                  end
                  default: begin
                     // Drive data only while the flash outputs float
                     state_next.pins.doe = 1'b1; // RQ7
                     state_next.st       = S_WR_WAIT;
                  end
               endcase
            end
         end
         S_RD_WAIT: begin
            if (state_reg.since_rp >= WAKE_CYC) begin // RQ12 RQ1
               state_next.pins.ce_n = 1'b0; // RQ6
               state_next.pins.oe_n = 1'b0; // RQ6 RQ24
               state_next.st        = S_RD_ACC;
            end
         end
         S_RD_ACC: begin
            state_next.cnt = state_reg.cnt + 8'h01;
            // Sample late: pin data passes two flops before use
            if (state_reg.cnt >= RD_END) begin
               state_next.rsp_d = state_reg.pins.word_wide ? data_sync
                                  : {8'h00, data_sync[7:0]}; // RQ22
               state_next.rsp_v     = 1'b1;
               state_next.pins.ce_n = 1'b1;
               state_next.pins.oe_n = 1'b1;
               state_next.cnt       = 8'h00;
               state_next.st        = S_IDLE;
            end
         end
         S_WR_WAIT: begin
            if (state_reg.since_rp >= W2_CYC) begin // RQ15 RQ16
               state_next.pins.ce_n = 1'b0;
               state_next.pins.we_n = 1'b0;
               state_next.st        = S_WR_LOW;
            end
         end
         S_WR_LOW: begin
            state_next.cnt = state_reg.cnt + 8'h01;
            if (state_reg.cnt >= WE_END) begin
               state_next.pins.we_n = 1'b1; // RQ21
               state_next.cnt       = 8'h00;
               state_next.st        = S_WR_HOLD;
            end
         end
         S_WR_HOLD: begin
            // Data held one cycle past the rising strobe for hold margin
            if (state_reg.two) begin
               state_next.two       = 1'b0;
               state_next.pins.dout = state_reg.data2; // RQ3
               state_next.pins.we_n = 1'b0;
               state_next.st        = S_WR_LOW;
            end else begin
               state_next.pins.ce_n = 1'b1; // RQ9
               state_next.pins.doe  = 1'b0; // RQ4
               state_next.rsp_v     = 1'b1;
               state_next.rsp_d     = 16'h0000;
               state_next.st        = S_IDLE;
            end
         end
         default: begin
            state_next = RST_VAL;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg <= RST_VAL;
      end else begin
         state_reg <= state_next;
      end
   end

   assign REQ_READY  = state_reg.rdy;
   assign RSP_VALID  = state_reg.rsp_v;
   assign RSP_DATA   = state_reg.rsp_d;
   assign FLASH_BUSY = state_reg.busy;
   assign PINS       = state_reg.pins;

   // ******************************************
   // Checks
   // ******************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   chk_read_pins: assert property ( // RQ6 RQ24
      !PINS.oe_n |-> !PINS.ce_n && PINS.we_n && PINS.rp_n)
      else $error("read cycle with bad control pins");

   chk_no_drive_read: assert property ( // RQ7
      PINS.doe |-> PINS.oe_n)
      else $error("host drives data while output gate active");

   chk_reset_width: assert property ( // RQ11
      $fell(PINS.rp_n) |-> !PINS.rp_n [*4])
      else $error("reset low too short");

   chk_wake_read: assert property ( // RQ12
      $fell(PINS.oe_n) |-> state_reg.since_rp >= WAKE_CYC)
      else $error("read before wake time");

   chk_write_gap: assert property ( // RQ15
      $fell(PINS.we_n) |-> state_reg.since_rp >= W2_CYC && PINS.rp_n)
      else $error("write before reset-to-write interval");

   chk_data_hold: assert property ( // RQ21
      $rose(PINS.we_n) |-> PINS.doe && !PINS.ce_n && $stable(PINS.dout)
      && $stable(PINS.addr))
      else $error("data or address moved at strobe edge");

   chk_two_step: assert property ( // RQ3
      $rose(PINS.we_n) && state_reg.two |-> ##[1:2] $fell(PINS.we_n))
      else $error("confirm write missing");

   chk_rp_quiet: assert property ( // RQ16
      !PINS.rp_n |-> PINS.we_n && PINS.oe_n && PINS.ce_n)
      else $error("access while reset low");

   chk_read_len: assert property ( // RQ6
      $fell(PINS.oe_n) |-> !PINS.oe_n [*6] ##1 RSP_VALID)
      else $error("read response timing wrong");

endmodule : fbc_ctrl

// ---- logic/fbc_pkg.sv ----
// Package of constants and types for the flash bus controller
package fbc_pkg;

   // ******************************************
   // Clock and pin timing
   // ******************************************
   localparam int CLK_NS       = 25;
   localparam int RST_LOW_NS   = 100;
   localparam int RST_LOW_CYC  = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAKE_NS_DEF  = 1000;
   localparam int W2_NS_DEF    = 1000;
   localparam int RD_CYC_DEF   = 4;
   localparam int WE_CYC_DEF   = 2;
   localparam int SYNC_CYC     = 2;

   // ******************************************
   // Array layout, bottom boot, word addresses
   // ******************************************
   localparam logic [18:0] BOOT_BLK_WORDS  = 19'h01000;
   localparam logic [18:0] PARAM_BLK_WORDS = 19'h01000;
   localparam logic [18:0] MAIN_BLK_WORDS  = 19'h08000;
   localparam logic [18:0] PARAM_BASE      = 19'h02000;
   localparam logic [18:0] MAIN_BASE       = 19'h08000;
   localparam logic [18:0] ARRAY_TOP       = 19'h7ffff;
   localparam int          BOOT_BLKS       = 2;
   localparam int          PARAM_BLKS      = 6;
   localparam int          MAIN_BLKS       = 15;

   // ******************************************
   // Request codes and states
   // ******************************************
   typedef enum logic [1:0] {
      OP_READ   = 2'b00,
      OP_WRITE  = 2'b01,
      OP_WRITE2 = 2'b10,
      OP_RESET  = 2'b11
   } fbc_op_t;

   typedef enum logic [2:0] {
      S_RST_LOW = 3'b000,
      S_IDLE    = 3'b001,
      S_RD_WAIT = 3'b010,
      S_RD_ACC  = 3'b011,
      S_WR_WAIT = 3'b100,
      S_WR_LOW  = 3'b101,
      S_WR_HOLD = 3'b110
   } fbc_state_t;

   typedef struct packed {
      fbc_op_t     op;
      logic [18:0] addr;
      logic        addr_lsb;
      logic [15:0] data;
      logic [15:0] data2;
   } fbc_req_t;

   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        rp_n;
      logic [18:0] addr;
      logic        addr_lsb;
      logic        word_wide;
      logic [15:0] dout;
      logic        doe;
   } fbc_pins_t;

   localparam logic [9:0] SINCE_MAX = 10'h3ff;

endpackage : fbc_pkg

// ---- logic/fbc_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module fbc_sync #(
   parameter int W = 1
) (
   input  wire logic         CLK,
   input  wire logic         RST,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : fbc_sync

// ---- tb/fbc_flash_model.sv ----
// Behavioural flash device on the far side of the bus controller
`timescale 1ns/1ps
module fbc_flash_model
   import fbc_pkg::*;
#(
   parameter int          WAKE_NS = 100,
   parameter int          W2_NS   = 100,
   parameter int          BUSY_NS = 1000,
   parameter logic [15:0] ID_CODE = 16'h5a3c, // Arbitrary value
   parameter logic [3:0]  LOCK_WA = 4'hf      // Word standing in for a locked block
) (
   input  wire fbc_pins_t   pins,
   output logic [15:0]      wire_dq,
   output logic             ready_busy_out,
   output int               viol
);
   // ******************************************
   // State
   // ******************************************
   logic [15:0] mem [16];
   logic [1:0]  mode;
   logic        armed, busy, aborted, susp;
   logic [15:0] last_q, src, wd;
   logic [3:0]  wa;
   realtime     t_fall, t_rise;
   event        start_ev;
   wire         drive = !pins.ce_n && !pins.oe_n && pins.rp_n;
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'hc3a0 + 16'(i * 17);
      mode = 2'h0; armed = 0; busy = 0; aborted = 0; viol = 0;
      susp = 0;
      last_q = 16'h0; t_fall = 0; t_rise = 0;
   end
   // ******************************************
   // Reset pin
   // ******************************************
   always @(negedge pins.rp_n) begin
      t_fall = $realtime;
      aborted = busy;
      busy = 0;
      susp = 0;
   end
   always @(posedge pins.rp_n) begin
      if ($realtime - t_fall < 100) viol++;
      t_rise = $realtime;
      mode = 2'h0; armed = 0; aborted = 0;
   end
   // ******************************************
   // Writes, latched on the strobe's rising edge
   // ******************************************
   always @(posedge pins.we_n) begin
      if (!pins.ce_n && pins.rp_n) begin
         if (armed) begin
            wa = pins.addr[3:0];
            wd = pins.dout;
            armed = 0;
            mode = 2'h2;
            // Locked block: confirm is taken but nothing starts
            if (pins.addr[3:0] != LOCK_WA) begin
               ->start_ev;
            end
         end else begin
            case (pins.dout[7:0])
               8'hff: mode = 2'h0;
               8'h90: mode = 2'h1;
               8'h70: mode = 2'h2;
               8'h40: armed = 1;
               8'hb0: begin
                  mode = 2'h2;
                  susp = busy;
               end
               8'hd0: begin
                  mode = 2'h2;
                  susp = 0;
               end
               default: ;
            endcase
         end
      end
   end
   // Gap is measured to the falling strobe, where the write starts
   always @(negedge pins.we_n) begin
      if (pins.rp_n && $realtime - t_rise < W2_NS) viol++;
   end
   // Runs on when deselected; a reset clears busy and drops the result
   always @(start_ev) begin
      busy = 1;
      for (int k = 0; k < BUSY_NS && busy; k++) begin
         #1;
         wait (!susp || !busy);
      end
      if (busy) mem[wa] = wd;
      busy = 0;
   end
   assign ready_busy_out = !((busy && !susp) || aborted);
   // ******************************************
   // Read path and wire level
   // ******************************************
   always @(negedge pins.oe_n) begin
      if (!pins.we_n || !pins.rp_n) viol++;
      if ($realtime - t_rise < WAKE_NS) viol++;
   end
   always @* begin
      if (mode == 2'h0) src = mem[pins.addr[3:0]];
      else if (mode == 2'h1) src = ID_CODE;
      else src = {8'h00, (busy && !susp) ? 8'h00 : 8'h80};
   end
   always @(negedge drive) last_q = src;
   always @(negedge pins.doe) last_q = pins.dout;
   // No pull on the data lines, so floating lines show the inverse
   always @* begin
      if (pins.doe) wire_dq = pins.dout;
      else if (drive && pins.word_wide) wire_dq = src;
      else if (drive) wire_dq = {~src[15:8], pins.addr_lsb ? src[15:8] : src[7:0]};
      else wire_dq = ~last_q;
   end
endmodule : fbc_flash_model

// ---- tb/tb.sv ----
// Self-checking testbench for the flash bus controller
`timescale 1ns/1ps
module tb;
   import fbc_pkg::*;
   logic        CLK = 0, RST = 1, REQ_VALID = 0, WORD_MODE = 1;
   fbc_req_t    REQ = '0;
   logic        REQ_READY, RSP_VALID, FLASH_BUSY, READY_BUSY_OUT;
   logic [15:0] RSP_DATA, DATA_IN, rd;
   fbc_pins_t   PINS;
   int          n_mismatch = 0, num_checks = 0, viol;
   always #12.5 CLK = ~CLK;
   fbc_ctrl #(.WAKE_NS(100), .W2_NS(100)) DUT (
      .CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ(REQ), .WORD_MODE(WORD_MODE),
      .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
      .FLASH_BUSY(FLASH_BUSY), .PINS(PINS), .DATA_IN(DATA_IN),
      .READY_BUSY_OUT(READY_BUSY_OUT));
   fbc_flash_model #(.WAKE_NS(100), .W2_NS(100)) FLASH (
      .pins(PINS), .wire_dq(DATA_IN), .ready_busy_out(READY_BUSY_OUT), .viol(viol));
   // ******************************************
   // Shared tasks
   // ******************************************
   function automatic logic [15:0] init_word(input int i);
      return 16'hc3a0 + 16'(i * 17);
   endfunction : init_word
   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check16
   // Bounded waits; a hang shows up as a failed compare
   task automatic xfer(input fbc_op_t op, input logic [18:0] a, input logic lsb,
                       input logic [15:0] d, input logic [15:0] d2);
      int n;
      n = 0;
      @(negedge CLK);
      REQ_VALID = 1;
      REQ = '{op, a, lsb, d, d2};
      while (REQ_READY !== 1'b1 && n < 2000) begin @(negedge CLK); n++; end
      @(negedge CLK);
      REQ_VALID = 0;
      if (op == OP_RESET) begin
         while (REQ_READY !== 1'b1 && n < 2000) begin @(negedge CLK); n++; end
      end else begin
         while (RSP_VALID !== 1'b1 && n < 2000) begin @(negedge CLK); n++; end
      end
      rd = RSP_DATA;
      if (n >= 2000) check16(16'(n), 16'h0000);
   endtask : xfer
   task automatic read_chk(input logic [18:0] a, input logic lsb, input logic [15:0] exp);
      xfer(OP_READ, a, lsb, 16'h0, 16'h0);
      check16(rd, exp);
   endtask : read_chk
   // ******************************************
   // Scenarios
   // ******************************************
   task automatic t_modes();
      read_chk(19'h00003, 1'b0, init_word(3));
      xfer(OP_WRITE, 19'h00000, 1'b0, 16'h0090, 16'h0);
      read_chk(19'h00001, 1'b0, 16'h5a3c);
      xfer(OP_WRITE, 19'h00000, 1'b0, 16'h0070, 16'h0);
      read_chk(19'h00001, 1'b0, 16'h0080);
      xfer(OP_WRITE, 19'h00000, 1'b0, 16'h00ff, 16'h0);
      read_chk(19'h00004, 1'b0, init_word(4));
      $display("test modes done");
   endtask : t_modes
   task automatic t_byte();
      WORD_MODE = 0;
      read_chk(19'h00005, 1'b0, {8'h00, 8'(init_word(5))});
      read_chk(19'h00005, 1'b1, {8'h00, 8'(init_word(5) >> 8)});
      WORD_MODE = 1;
      $display("test byte done");
   endtask : t_byte
   task automatic t_stray();
      xfer(OP_WRITE, 19'h00006, 1'b0, 16'h1234, 16'h0);
      read_chk(19'h00006, 1'b0, init_word(6));
      xfer(OP_WRITE2, 19'h0000f, 1'b0, 16'h0040, 16'h5555);
      xfer(OP_WRITE, 19'h00000, 1'b0, 16'h00ff, 16'h0);
      read_chk(19'h0000f, 1'b0, init_word(15));
      $display("test stray done");
   endtask : t_stray
   task automatic t_program();
      int n;
      n = 0;
      xfer(OP_WRITE2, 19'h00007, 1'b0, 16'h0040, 16'hbeef);
      repeat (4) @(negedge CLK);
      check16({15'h0, FLASH_BUSY}, 16'h0001);
      read_chk(19'h00007, 1'b0, 16'h0000);
      xfer(OP_WRITE, 19'h00000, 1'b0, 16'h00b0, 16'h0);
      repeat (4) @(negedge CLK);
      check16({15'h0, FLASH_BUSY}, 16'h0000);
      xfer(OP_WRITE, 19'h00000, 1'b0, 16'h00ff, 16'h0);
      read_chk(19'h00003, 1'b0, init_word(3));
      xfer(OP_WRITE, 19'h00000, 1'b0, 16'h00d0, 16'h0);
      repeat (4) @(negedge CLK);
      check16({15'h0, FLASH_BUSY}, 16'h0001);
      while (FLASH_BUSY !== 1'b0 && n < 200) begin @(negedge CLK); n++; end
      check16({15'h0, FLASH_BUSY}, 16'h0000);
      read_chk(19'h00007, 1'b0, 16'h0080);
      xfer(OP_WRITE, 19'h00000, 1'b0, 16'h00ff, 16'h0);
      read_chk(19'h00007, 1'b0, 16'hbeef);
      $display("test program done");
   endtask : t_program
   task automatic t_abort();
      xfer(OP_WRITE2, 19'h00008, 1'b0, 16'h0040, 16'h1111);
      repeat (4) @(negedge CLK);
      check16({15'h0, FLASH_BUSY}, 16'h0001);
      xfer(OP_RESET, 19'h00000, 1'b0, 16'h0, 16'h0);
      // Write straight after reset must wait out the gap
      xfer(OP_WRITE, 19'h00000, 1'b0, 16'h0000, 16'h0);
      repeat (4) @(negedge CLK);
      check16({15'h0, FLASH_BUSY}, 16'h0000);
      read_chk(19'h00009, 1'b0, init_word(9));
      check16(16'(viol), 16'h0000);
      $display("test abort done");
   endtask : t_abort
   task automatic t_layout();
      check16({15'h0, PARAM_BASE == 19'(BOOT_BLKS) * BOOT_BLK_WORDS}, 16'h0001);
      check16({15'h0, MAIN_BASE == PARAM_BASE + 19'(PARAM_BLKS) * PARAM_BLK_WORDS},
              16'h0001);
      check16({15'h0, 19'h7ffff == MAIN_BASE + 19'(MAIN_BLKS) * MAIN_BLK_WORDS - 19'h00001},
              16'h0001);
      $display("test layout done");
   endtask : t_layout
   // ******************************************
   // Sequence and verdict
   // ******************************************
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (5) @(posedge CLK);
      @(negedge CLK);
      RST = 0;
      t_layout();
      t_modes();
      t_byte();
      t_stray();
      t_program();
      t_abort();
      conclude();
   end
   // Whole run needs well under 1000 cycles
   initial begin
      #(25 * 20000);
      n_mismatch++;
      conclude();
   end
endmodule : tb
